// ---- chpwm_params.svh ----
`ifndef CHPWM_PARAMS_SVH
`define CHPWM_PARAMS_SVH
// Register indices; each register is one 16-bit word
`define CHPWM_ADDR_PWM 5'h0E
`define CHPWM_ADDR_ILIM 5'h0F
`define CHPWM_RST_PWM 16'h0000
`define CHPWM_RST_ILIM 16'h0088
`define CHPWM_PWM_WMASK 16'h0FFF
// Field positions
`define CHPWM_FREQ_HI 11
`define CHPWM_FREQ_LO 9
`define CHPWM_DTY_HI 8
`define CHPWM_DTY_LO 1
`define CHPWM_EN_BIT 0
`define CHPWM_PEAK_HI 15
`define CHPWM_PEAK_LO 14
`define CHPWM_CHG_HI 13
`define CHPWM_CHG_LO 12
`define CHPWM_FUSE_BIT 11
`define CHPWM_WIN_HI 10
`define CHPWM_WIN_LO 8
`define CHPWM_LVL_HI 7
`define CHPWM_LVL_LO 4
`define CHPWM_THR_HI 3
`define CHPWM_THR_LO 0
// Timing
`define CHPWM_CLK_HZ 20000000
`define CHPWM_MIN_ON_US 200
`define CHPWM_MIN_ON_CYC ((`CHPWM_MIN_ON_US * (`CHPWM_CLK_HZ / 1000)) / 1000)
`define CHPWM_MS_CYC (`CHPWM_CLK_HZ / 1000)
// Period in cycles for each frequency code (20 MHz / f, rounded down)
`define CHPWM_PER_0 32'd25000000
`define CHPWM_PER_1 32'd5882352
`define CHPWM_PER_2 32'd1449275
`define CHPWM_PER_3 32'd180180
`define CHPWM_PER_4 32'd90497
`define CHPWM_PER_5 32'd45146
`define CHPWM_PER_6 32'd22598
`define CHPWM_PER_7 32'd11299
// Inrush window lengths in ms per code
`define CHPWM_WIN_0 8'd0
`define CHPWM_WIN_1 8'd2
`define CHPWM_WIN_2 8'd4
`define CHPWM_WIN_3 8'd6
`define CHPWM_WIN_4 8'd10
`define CHPWM_WIN_5 8'd20
`define CHPWM_WIN_6 8'd50
`define CHPWM_WIN_7 8'd100
// Current codes in units of 0.1 A
`define CHPWM_MAX_THR 4'hC
`endif

// ---- chpwm_pkg.sv ----
package chpwm_pkg;
    typedef enum logic [1:0] {
        CHPWM_CHG_NONE = 2'b00,
        CHPWM_CHG_RAMP = 2'b01,
        CHPWM_CHG_ILIM = 2'b10,
        CHPWM_CHG_PULSE = 2'b11
    } chpwm_chg_e;
    typedef enum logic [1:0] {
        CHPWM_ST_OFF = 2'b00,
        CHPWM_ST_INRUSH = 2'b01,
        CHPWM_ST_RUN = 2'b10
    } chpwm_state_e;
    typedef logic [10:0] chpwm_amp_t;
endpackage

// ---- chpwm_channel.sv ----
// How it works
// - Bits 11-9 pick the modulation period from eight codes, 0.8 Hz up to 1770 Hz.
// - Bits 8-1 set the on time as code/256 of the period, full on at the top code.
// - Modulation runs only when the on time exceeds 200 us, else a fault flag is raised.
// - The modulation enable is refused unless the charging mode field is 00.
// - Enable clear: output follows the switch command; set: output pulses while commanded on.
// - In pulse charging mode bits 15-14 give the pulse peak of 47.5, 55, 62.5 or 70 A.
// - Bits 13-12 select none, voltage ramp, current regulation or current pulse charging.
// - During the inrush window inrush settings apply and modulation and fuse are held off.
// - The fuse enable may be set early; accumulation starts only after the window ends.
// - Bits 10-8 give an inrush window of 0, 2, 4, 6, 10, 20, 50 or 100 ms.
// - With no charging mode bits 7-4 give the inrush threshold on the steady table.
// - In current regulation mode the limit is the steady table value of bits 7-4 over 5.
// - In ramp mode bits 7-4 give the ramp code; only eight codes are valid.
// - In pulse mode bits 7-4 pass on as pulse parameters, not as a threshold.
// - Bits 3-0 set the steady threshold, 10 A to 70 A for codes 0 to C.
`timescale 1ns/10ps
`default_nettype none
`include "chpwm_params.svh"
module chpwm_channel #(
    parameter int MS_CYC = `CHPWM_MS_CYC,
    parameter int MIN_ON_CYC = `CHPWM_MIN_ON_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input wire logic switch_on_command_i,
    output logic ch1_out_o,
    output logic ch1_modulation_error_o,
    output logic ch1_inrush_active_o,
    output logic ch1_fuse_accumulate_o,
    output chpwm_pkg::chpwm_chg_e ch1_charging_mode_o,
    output chpwm_pkg::chpwm_amp_t ch1_active_threshold_o,
    output logic [3:0] ch1_ramp_or_pulse_param_o,
    output logic ch1_ramp_code_valid_o
);
    import chpwm_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (MS_CYC < 1 || MIN_ON_CYC < 1)
    begin
        $error("chpwm_channel: cycle counts must be at least one");
    end

    // ------------------------------------------------------------
    // Lookup functions
    // ------------------------------------------------------------
    function automatic logic [31:0] period_cyc(input logic [2:0] code);
        case (code)
            3'h0: period_cyc = `CHPWM_PER_0;
            3'h1: period_cyc = `CHPWM_PER_1;
            3'h2: period_cyc = `CHPWM_PER_2;
            3'h3: period_cyc = `CHPWM_PER_3;
            3'h4: period_cyc = `CHPWM_PER_4;
            3'h5: period_cyc = `CHPWM_PER_5;
            3'h6: period_cyc = `CHPWM_PER_6;
            default: period_cyc = `CHPWM_PER_7;
        endcase
    endfunction

    function automatic logic [7:0] window_ms(input logic [2:0] code);
        case (code)
            3'h0: window_ms = `CHPWM_WIN_0;
            3'h1: window_ms = `CHPWM_WIN_1;
            3'h2: window_ms = `CHPWM_WIN_2;
            3'h3: window_ms = `CHPWM_WIN_3;
            3'h4: window_ms = `CHPWM_WIN_4;
            3'h5: window_ms = `CHPWM_WIN_5;
            3'h6: window_ms = `CHPWM_WIN_6;
            default: window_ms = `CHPWM_WIN_7;
        endcase
    endfunction

    // Steady table in 0.1 A units; unsupported codes clamp to top
    function automatic chpwm_amp_t amp_of(input logic [3:0] code);
        case (code)
            4'h0: amp_of = 11'd100;
            4'h1: amp_of = 11'd125;
            4'h2: amp_of = 11'd150;
            4'h3: amp_of = 11'd175;
            4'h4: amp_of = 11'd200;
            4'h5: amp_of = 11'd225;
            4'h6: amp_of = 11'd250;
            4'h7: amp_of = 11'd325;
            4'h8: amp_of = 11'd400;
            4'h9: amp_of = 11'd475;
            4'hA: amp_of = 11'd550;
            4'hB: amp_of = 11'd625;
            default: amp_of = 11'd700;
        endcase
    endfunction

    // Ramp rates exist for eight codes only
    function automatic logic ramp_code_ok(input logic [3:0] code);
        case (code)
            4'h3, 4'h5, 4'h6, 4'h7: ramp_code_ok = 1'b1;
            4'h9, 4'hA, 4'hB, 4'hC: ramp_code_ok = 1'b1;
            default: ramp_code_ok = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] pwm_q;
    logic [15:0] pwm_d;
    logic [15:0] ilim_q;
    logic [15:0] ilim_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    wire sel_pwm = reg_addr_i == `CHPWM_ADDR_PWM;
    wire sel_ilim = reg_addr_i == `CHPWM_ADDR_ILIM;
    wire wr_pwm = reg_wr_i && sel_pwm;
    wire wr_ilim = reg_wr_i && sel_ilim;

    wire [1:0] chg_now = ilim_q[`CHPWM_CHG_HI:`CHPWM_CHG_LO];
    wire [1:0] chg_next = wr_ilim ? reg_wdata_i[`CHPWM_CHG_HI:`CHPWM_CHG_LO] : chg_now;
    // Enable refused while any charging mode is selected
    wire en_allowed = chg_next == CHPWM_CHG_NONE;
    wire en_req = wr_pwm ? reg_wdata_i[`CHPWM_EN_BIT] : pwm_q[`CHPWM_EN_BIT];
    wire [15:0] pwm_wr_val = wr_pwm ? (reg_wdata_i & `CHPWM_PWM_WMASK) : pwm_q;

    assign pwm_d = {pwm_wr_val[15:1], en_req & en_allowed};
    assign ilim_d = wr_ilim ? reg_wdata_i : ilim_q;

    // Unmapped indices read zero
    assign rdata_d = sel_pwm ? pwm_q : (sel_ilim ? ilim_q : 16'h0000);

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            pwm_q <= `CHPWM_RST_PWM;
            ilim_q <= `CHPWM_RST_ILIM;
        end
        else
        begin
            pwm_q <= pwm_d;
            ilim_q <= ilim_d;
        end
    end

    // Read data registered one cycle behind the index
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q <= 16'h0000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire [2:0] freq_code = pwm_q[`CHPWM_FREQ_HI:`CHPWM_FREQ_LO];
    wire [7:0] duty_code = pwm_q[`CHPWM_DTY_HI:`CHPWM_DTY_LO];
    wire mod_en = pwm_q[`CHPWM_EN_BIT];
    wire [1:0] peak_code = ilim_q[`CHPWM_PEAK_HI:`CHPWM_PEAK_LO];
    wire fuse_en = ilim_q[`CHPWM_FUSE_BIT];
    wire [2:0] win_code = ilim_q[`CHPWM_WIN_HI:`CHPWM_WIN_LO];
    wire [3:0] lvl_code = ilim_q[`CHPWM_LVL_HI:`CHPWM_LVL_LO];
    wire [3:0] thr_code = ilim_q[`CHPWM_THR_HI:`CHPWM_THR_LO];
    wire chpwm_chg_e chg_mode = chpwm_chg_e'(chg_now);

    wire [31:0] period = period_cyc(freq_code);
    wire [39:0] on_prod = period * duty_code;
    // Full on at the top code, code/256 otherwise
    wire [31:0] on_cyc = (duty_code == 8'hFF) ? period : on_prod[39:8];
    wire on_ok = on_cyc > 32'(MIN_ON_CYC);

    // Pulse peak codes 0..3 are taken as steps 9..C of the steady table
    wire [3:0] peak_idx = 4'h9 + {2'b00, peak_code};
    wire chpwm_amp_t amp_peak = amp_of(peak_idx);
    wire chpwm_amp_t amp_lvl = amp_of(lvl_code);
    wire chpwm_amp_t amp_reg = amp_lvl / 11'd5;
    wire chpwm_amp_t amp_steady = amp_of(thr_code);
    wire ramp_ok = ramp_code_ok(lvl_code);

    // ------------------------------------------------------------
    // Channel sequence
    // ------------------------------------------------------------
    chpwm_state_e st_q;
    chpwm_state_e st_d;
    logic [7:0] ms_left_q;
    logic [7:0] ms_left_d;
    logic [31:0] ms_tick_q;
    logic [31:0] ms_tick_d;

    wire [7:0] win_len = window_ms(win_code);
    wire tick_end = ms_tick_q == 32'(MS_CYC - 1);

    always_comb
    begin
        st_d = st_q;
        ms_left_d = ms_left_q;
        ms_tick_d = 32'd0;
        case (st_q)
            CHPWM_ST_OFF:
            begin
                if (switch_on_command_i)
                begin
                    ms_left_d = win_len;
                    st_d = (win_len == 8'd0) ? CHPWM_ST_RUN : CHPWM_ST_INRUSH;
                end
            end
            CHPWM_ST_INRUSH:
            begin
                ms_tick_d = tick_end ? 32'd0 : ms_tick_q + 32'd1;
                if (!switch_on_command_i)
                begin
                    st_d = CHPWM_ST_OFF;
                end
                else if (tick_end)
                begin
                    ms_left_d = ms_left_q - 8'd1;
                    if (ms_left_q == 8'd1)
                    begin
                        st_d = CHPWM_ST_RUN;
                    end
                end
            end
            CHPWM_ST_RUN:
            begin
                if (!switch_on_command_i)
                begin
                    st_d = CHPWM_ST_OFF;
                end
            end
            default: st_d = CHPWM_ST_OFF;
        endcase
    end

    wire in_window = st_d == CHPWM_ST_INRUSH;
    wire running = st_d == CHPWM_ST_RUN;

    // ------------------------------------------------------------
    // Modulation
    // ------------------------------------------------------------
    logic [31:0] phase_q;
    logic [31:0] phase_d;
    wire mod_active = mod_en && on_ok && running;
    assign phase_d = (!mod_active || phase_q >= period - 32'd1) ? 32'd0 : phase_q + 32'd1;
    // Output follows command, or pulses while commanded on
    wire out_d = mod_active ? (phase_d < on_cyc) : switch_on_command_i;

    chpwm_amp_t thr_d;
    always_comb
    begin
        thr_d = amp_steady;
        if (in_window)
        begin
            case (chg_mode)
                CHPWM_CHG_NONE: thr_d = amp_lvl;
                CHPWM_CHG_ILIM: thr_d = amp_reg;
                CHPWM_CHG_PULSE: thr_d = amp_peak;
                default: thr_d = amp_steady;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= CHPWM_ST_OFF;
            ms_left_q <= 8'd0;
            ms_tick_q <= 32'd0;
            phase_q <= 32'd0;
        end
        else
        begin
            st_q <= st_d;
            ms_left_q <= ms_left_d;
            ms_tick_q <= ms_tick_d;
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------
    // Output drive and status
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ch1_out_o <= 1'b0;
            ch1_modulation_error_o <= 1'b0;
        end
        else
        begin
            ch1_out_o <= out_d;
            ch1_modulation_error_o <= mod_en && !on_ok;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ch1_inrush_active_o <= 1'b0;
            ch1_fuse_accumulate_o <= 1'b0;
        end
        else
        begin
            ch1_inrush_active_o <= in_window;
            ch1_fuse_accumulate_o <= fuse_en && running;
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ch1_charging_mode_o <= CHPWM_CHG_NONE;
            ch1_active_threshold_o <= 11'd0;
            ch1_ramp_or_pulse_param_o <= 4'h0;
            ch1_ramp_code_valid_o <= 1'b0;
        end
        else
        begin
            ch1_charging_mode_o <= chg_mode;
            ch1_active_threshold_o <= thr_d;
            ch1_ramp_or_pulse_param_o <= lvl_code;
            ch1_ramp_code_valid_o <= ramp_ok;
        end
    end

    assign reg_rdata_o = rdata_q;
endmodule
`default_nettype wire

// ---- chpwm_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Host side register access
// ----------------------------------------
module chpwm_host (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic [4:0] addr_o,
    output logic wr_o,
    output logic [15:0] wdata_o
);
    initial
    begin
        addr_o = 5'h00;
        wr_o = 1'b0;
        wdata_o = 16'h5A5A;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        wr_o = 1'b1;
        wdata_o = (a == 5'h0F && d[3:0] > 4'hC) ? {d[15:4], 4'hC} : d;
        @(negedge clk_i);
        wr_o = 1'b0;
        // Released data line flips
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        @(negedge clk_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// ---- chpwm_channel_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port level checks
// ----------------------------------------
module chpwm_channel_properties #(
    parameter int MS_CYC = 20000,
    parameter int MIN_ON_CYC = 4000
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic switch_on_command_i,
    input wire logic ch1_out_o,
    input wire logic ch1_modulation_error_o,
    input wire logic ch1_inrush_active_o,
    input wire logic ch1_fuse_accumulate_o,
    input wire chpwm_pkg::chpwm_chg_e ch1_charging_mode_o,
    input wire chpwm_pkg::chpwm_amp_t ch1_active_threshold_o,
    input wire logic [3:0] ch1_ramp_or_pulse_param_o,
    input wire logic ch1_ramp_code_valid_o
);
    import chpwm_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_unmapped_zero: assert property (!(reg_addr_i inside {5'h0E, 5'h0F})
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    a_reserved_zero: assert property (reg_addr_i == 5'h0E |=> reg_rdata_o[15:12] == 4'h0)
        else $error("reserved bits not zero");
    a_off_output: assert property (!switch_on_command_i [*3] |=> !ch1_out_o)
        else $error("output on while switch off");
    a_fuse_off: assert property (!switch_on_command_i [*3] |=> !ch1_fuse_accumulate_o)
        else $error("fuse runs while switch off");
    a_inrush_fuse: assert property (ch1_inrush_active_o |-> !ch1_fuse_accumulate_o)
        else $error("fuse runs in inrush window");
    a_inrush_steady: assert property (ch1_inrush_active_o |-> ch1_out_o)
        else $error("output modulated in inrush window");
    a_ramp_valid: assert property (ch1_ramp_code_valid_o == (ch1_ramp_or_pulse_param_o
        inside {4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC})) else $error("ramp valid wrong");
    a_pulse_peak: assert property (ch1_inrush_active_o &&
        ch1_charging_mode_o == CHPWM_CHG_PULSE
        |-> ch1_active_threshold_o inside {11'h1DB, 11'h226, 11'h271, 11'h2BC})
        else $error("pulse peak wrong");
    a_ilim_div: assert property (ch1_inrush_active_o &&
        ch1_charging_mode_o == CHPWM_CHG_ILIM
        |-> ch1_active_threshold_o inside {11'h014, 11'h019, 11'h01E, 11'h023, 11'h028,
        11'h02D, 11'h032, 11'h041, 11'h050, 11'h05F, 11'h06E, 11'h07D, 11'h08C})
        else $error("regulation level wrong");
    a_inrush_none: assert property (ch1_inrush_active_o &&
        ch1_charging_mode_o == CHPWM_CHG_NONE
        |-> ch1_active_threshold_o inside {11'h064, 11'h07D, 11'h096, 11'h0AF, 11'h0C8,
        11'h0E1, 11'h0FA, 11'h145, 11'h190, 11'h1DB, 11'h226, 11'h271, 11'h2BC})
        else $error("inrush threshold wrong");
endmodule
`default_nettype wire

// ---- channel_pwm_and_current_limit_config_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module channel_pwm_and_current_limit_config_tb;
    import chpwm_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic switch_on_command_i = 1'b0;
    wire logic [4:0] reg_addr_i;
    wire logic reg_wr_i;
    wire logic [15:0] reg_wdata_i;
    logic [15:0] reg_rdata_o, rv;
    logic ch1_out_o, ch1_modulation_error_o, ch1_inrush_active_o, ch1_fuse_accumulate_o;
    chpwm_chg_e ch1_charging_mode_o;
    chpwm_amp_t ch1_active_threshold_o;
    logic [3:0] ch1_ramp_or_pulse_param_o;
    logic ch1_ramp_code_valid_o;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int hi = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    chpwm_channel #(.MS_CYC(10), .MIN_ON_CYC(20)) DUT (.clk_sys_i, .rst_n_i, .reg_addr_i,
        .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .switch_on_command_i, .ch1_out_o,
        .ch1_modulation_error_o, .ch1_inrush_active_o, .ch1_fuse_accumulate_o,
        .ch1_charging_mode_o, .ch1_active_threshold_o, .ch1_ramp_or_pulse_param_o,
        .ch1_ramp_code_valid_o);
    chpwm_host u_host (.clk_i(clk_sys_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
        .wr_o(reg_wr_i), .wdata_o(reg_wdata_i));
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // Program current limit, then switch off for four cycles and back on
    task automatic swon(input logic [15:0] v);
        u_host.wr(5'h0F, v);
        switch_on_command_i = 1'b0;
        tick(4);
        switch_on_command_i = 1'b1;
        tick(3);
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    initial
    begin
        tick(12);
        rst_n_i = 1'b1;
        u_host.rd(5'h0E, rv);
        cmp("pwm_reset", 16'h0000, rv);
        u_host.rd(5'h0F, rv);
        cmp("ilim_reset", 16'h0088, rv);
        u_host.wr(5'h10, 16'hFFFF);
        u_host.rd(5'h10, rv);
        cmp("unmapped", 16'h0000, rv);
        u_host.wr(5'h0E, 16'hFFFF);
        u_host.rd(5'h0E, rv);
        cmp("pwm_rw", 16'h0FFF, rv);
        u_host.wr(5'h0E, 16'h0000);
        swon(16'h0948);
        cmp("inrush_on", 16'h0001, ch1_inrush_active_o);
        cmp("thr_inrush", 16'h00C8, ch1_active_threshold_o);
        cmp("fuse_held", 16'h0000, ch1_fuse_accumulate_o);
        cmp("out_follows", 16'h0001, ch1_out_o);
        tick(16);
        cmp("inrush_held", 16'h0001, ch1_inrush_active_o);
        tick(6);
        cmp("inrush_end", 16'h0000, ch1_inrush_active_o);
        cmp("thr_steady", 16'h0190, ch1_active_threshold_o);
        cmp("fuse_run", 16'h0001, ch1_fuse_accumulate_o);
        swon(16'h2188);
        cmp("mode_ilim", 16'h0002, ch1_charging_mode_o);
        cmp("thr_div", 16'h0050, ch1_active_threshold_o);
        for (int k = 0; k < 4; k++)
        begin
            swon({k[1:0], 14'h3188});
            cmp("pulse_peak", 16'h01DB + 16'h004B * k[1:0], ch1_active_threshold_o);
            cmp("pulse_par", 16'h0008, ch1_ramp_or_pulse_param_o);
        end
        swon(16'h0148);
        cmp("ramp_bad", 16'h0000, ch1_ramp_code_valid_o);
        swon(16'h1138);
        cmp("mode_ramp", 16'h0001, ch1_charging_mode_o);
        cmp("ramp_ok", 16'h0001, ch1_ramp_code_valid_o);
        u_host.wr(5'h0E, 16'h0E01);
        u_host.rd(5'h0E, rv);
        cmp("en_refused", 16'h0E00, rv);
        swon(16'h0008);
        u_host.wr(5'h0E, 16'h0001);
        tick(3);
        cmp("short_on_err", 16'h0001, ch1_modulation_error_o);
        u_host.wr(5'h0E, 16'h0F01);
        tick(3);
        cmp("long_on_ok", 16'h0000, ch1_modulation_error_o);
        repeat (11299)
        begin
            @(negedge clk_sys_i);
            if (ch1_out_o === 1'b1)
                hi++;
        end
        cmp("duty_half", 16'h0001, {15'h0000, hi > 5600 && hi < 5700});
        switch_on_command_i = 1'b0;
        tick(4);
        cmp("out_off", 16'h0000, ch1_out_o);
        give_verdict();
    end
endmodule
bind chpwm_channel chpwm_channel_properties #(.MS_CYC(MS_CYC), .MIN_ON_CYC(MIN_ON_CYC))
    u_props (.clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o,
    .switch_on_command_i, .ch1_out_o, .ch1_modulation_error_o, .ch1_inrush_active_o,
    .ch1_fuse_accumulate_o, .ch1_charging_mode_o, .ch1_active_threshold_o,
    .ch1_ramp_or_pulse_param_o, .ch1_ramp_code_valid_o);
`default_nettype wire
